// [ssi_defs.svh]
// Constants for the four-wire serial slave interface and its master end
`ifndef SSI_DEFS_SVH
`define SSI_DEFS_SVH

// =====================================================================
// Timing
`define SSI_SYS_NS        100
`define SSI_SCK_HALF_NS   400
`define SSI_HALF_CYC      ((`SSI_SCK_HALF_NS) / (`SSI_SYS_NS))
`define SSI_BITS          8

// =====================================================================
// Device register offsets
`define SSI_A_CTRL        3'h0
`define SSI_A_DATA        3'h1
`define SSI_A_ISTS        3'h2
`define SSI_A_IEN         3'h3
`define SSI_A_ICLR        3'h4

// =====================================================================
// Device control register fields and reset value
`define SSI_B_CLK_SRC     7
`define SSI_B_MODE_HI     6
`define SSI_B_MODE_LO     5
`define SSI_B_BUS_EN      4
`define SSI_B_ORDER       3
`define SSI_B_SEL_EN      2
`define SSI_B_COLL        1
`define SSI_B_DONE        0
`define SSI_CTRL_RST      8'h60
`define SSI_MODE_SLAVE    2'h0

// =====================================================================
// Interrupt status fields (device; the master uses the done bit only)
`define SSI_I_DONE        0
`define SSI_I_COLL        1

// =====================================================================
// Master end register offsets and fields, and the slave synchroniser reset
`define SSI_MA_CTRL       3'h0
`define SSI_MA_TX         3'h1
`define SSI_MA_RX         3'h2
`define SSI_MA_STS        3'h3
`define SSI_MA_IEN        3'h4
`define SSI_MA_ICLR       3'h5
`define SSI_MB_MSB        0
`define SSI_MB_BUSY       1
`define SSI_SYNC_RST      3'h2

`endif

// [ssi_pkg.sv]
// Types used by the master end of the serial interface
`default_nettype none

package ssi_pkg;

	// =================================================================
	// Master sequencer states
	typedef enum logic [1:0] {
		SSI_IDLE,
		SSI_SETUP,
		SSI_SHIFT,
		SSI_HOLD
	} ssi_mst_state_t;

endpackage

`default_nettype wire

// [ssi_if.sv]
// Four-wire serial link joining the master end and the slave device
`timescale 1ns/1ns
`default_nettype none

interface ssi_if;
	logic sck;
	logic ss_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	wire  miso;

	// Released data line is pulled high
	assign miso = miso_oe ? miso_o : 1'b1;

	modport dev (
		input  sck,
		input  ss_n,
		input  mosi,
		output miso_o,
		output miso_oe
	);

	modport mst (
		output sck,
		output ss_n,
		output mosi,
		input  miso
	);
endinterface

`default_nettype wire

// [ssi_slave.sv]
// Serial slave device: control, data, interrupt and shift logic
`timescale 1ns/1ns
`default_nettype none
`include "ssi_defs.svh"

// Contract
// - Software writes mode code 00 for slave
// - Clock source select ignored in slave mode
// - Bit order bit picks MSB or LSB first
// - Software sets select, order, then enable
// - Written byte shifts out only when selected
// - Received byte copied to data when complete
// - Done flag and interrupt after each byte
// - Data write during transfer discarded, collision flagged
// - Collision flag set by hardware, cleared by software
// - Software rechecks collision and rewrites byte
// - Option enables or disables collision detection
// - Option lets select enable bit matter
// - Option fixes active clock edge
// - Transfers keep running in power-down
// - Control resets to mode bits one
// - Select enable low disables the interface
// - Bus enable low floats pins, high idles output
// - Non-zero mode codes mean master, not slave
module ssi_slave #(
	parameter bit COLL_OPT    = 1'b1,
	parameter bit SEL_EN_OPT  = 1'b1,
	parameter bit SAMPLE_RISE = 1'b1
) (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	output logic            irq,
	ssi_if.dev              link
);

	// =================================================================
	// Declarations
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic       sck_p_q;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] sh_q;
	logic [7:0] rx_q;
	logic [2:0] cnt_q;
	logic [1:0] ists_q;
	logic [1:0] ists_d;
	logic [1:0] ien_q;
	logic       irq_q;
	logic [7:0] rdata_q;
	logic       miso_q;
	logic       miso_oe_q;

	// =================================================================
	// Pin synchronisers: sck, select, data in; only stage two is read
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= `SSI_SYNC_RST;
			s2_q <= `SSI_SYNC_RST;
		end else begin
			s1_q <= {link.sck, link.ss_n, link.mosi};
			s2_q <= s1_q;
		end
	end

	// Previous synchronised clock level for edge finding
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_p_q <= 1'b0;
		end else begin
			sck_p_q <= s2_q[2];
		end
	end

	// =================================================================
	// Mode decode and link qualification
	wire sck_s      = s2_q[2];
	wire ss_act     = ~s2_q[1];
	wire mosi_s     = s2_q[0];
	// Clock source bit is never looked at; the master times all shifts
	wire [1:0] mode = {ctrl_q[`SSI_B_MODE_HI], ctrl_q[`SSI_B_MODE_LO]};
	wire slave_mode = (mode == `SSI_MODE_SLAVE);
	// With the option off the enable bit is bypassed, not obeyed
	wire sel_gate   = SEL_EN_OPT ? ctrl_q[`SSI_B_SEL_EN] : 1'b1;
	wire enabled    = ctrl_q[`SSI_B_BUS_EN] & slave_mode & sel_gate;
	wire busy       = enabled & ss_act;

	// =================================================================
	// Edge selection and shifting; power-down gates none of this
	wire rise       = sck_s & ~sck_p_q;
	wire fall       = ~sck_s & sck_p_q;
	wire sample     = busy & (SAMPLE_RISE ? rise : fall);
	wire msb_first  = ctrl_q[`SSI_B_ORDER];
	wire [7:0] shifted = msb_first ? {sh_q[6:0], mosi_s}
	                               : {mosi_s, sh_q[7:1]};
	wire out_bit    = msb_first ? sh_q[7] : sh_q[0];
	wire last       = sample & (cnt_q == 3'(`SSI_BITS - 1));

	// =================================================================
	// Register port decode
	wire wr_ctrl    = wr_stb & (addr == `SSI_A_CTRL);
	wire wr_data    = wr_stb & (addr == `SSI_A_DATA);
	wire wr_ien     = wr_stb & (addr == `SSI_A_IEN);
	wire wr_iclr    = wr_stb & (addr == `SSI_A_ICLR);
	wire collide    = wr_data & busy;
	wire load       = wr_data & ~busy;
	// With detection off a clash still drops the write but flags nothing
	wire coll_set   = collide & COLL_OPT;

	// Flags: hardware set beats a software clear in the same cycle
	wire coll_keep  = wr_ctrl ? (ctrl_q[`SSI_B_COLL] & wdata[`SSI_B_COLL])
	                          : ctrl_q[`SSI_B_COLL];
	wire done_keep  = wr_ctrl ? (ctrl_q[`SSI_B_DONE] & wdata[`SSI_B_DONE])
	                          : ctrl_q[`SSI_B_DONE];
	wire coll_d     = coll_set | coll_keep;
	wire done_d     = last | done_keep;
	wire [5:0] cfg_d = wr_ctrl ? wdata[7:2] : ctrl_q[7:2];
	assign ctrl_d   = {cfg_d, coll_d, done_d};

	// Interrupt status: sticky, cleared by writing ones, set wins
	wire [1:0] iclr = wr_iclr ? wdata[1:0] : 2'h0;
	wire [1:0] iset = {coll_set, last};
	assign ists_d   = (ists_q & ~iclr) | iset;

	// Read selection
	wire [7:0] rd_mux =
		(addr == `SSI_A_CTRL) ? ctrl_q :
		(addr == `SSI_A_DATA) ? rx_q :
		(addr == `SSI_A_ISTS) ? {6'h00, ists_q} :
		(addr == `SSI_A_IEN)  ? {6'h00, ien_q} : 8'h00;

	// =================================================================
	// Control register; mode bits come up as one
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `SSI_CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Shift buffer: software loads it only while idle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_q <= 8'h00;
		end else if (sample) begin
			sh_q <= shifted;
		end else if (load) begin
			sh_q <= wdata;
		end
	end

	// Bit counter restarts whenever the select drops away
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 3'h0;
		end else if (!busy) begin
			cnt_q <= 3'h0;
		end else if (sample) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end

	// Readable data updates only once the whole byte is in
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_q <= 8'h00;
		end else if (last) begin
			rx_q <= shifted;
		end
	end

	// =================================================================
	// Interrupt status, enable and output
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ists_q <= 2'h0;
			ien_q  <= 2'h0;
			irq_q  <= 1'b0;
		end else begin
			ists_q <= ists_d;
			ien_q  <= wr_ien ? wdata[1:0] : ien_q;
			irq_q  <= |(ists_q & ien_q);
		end
	end

	// =================================================================
	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_stb ? rd_mux : 8'h00;
		end
	end

	// Data out: idles high while enabled, released otherwise
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			miso_q    <= 1'b1;
			miso_oe_q <= 1'b0;
		end else begin
			miso_q    <= busy ? out_bit : 1'b1;
			miso_oe_q <= enabled;
		end
	end

	// =================================================================
	// Outputs
	assign rdata       = rdata_q;
	assign irq         = irq_q;
	assign link.miso_o  = miso_q;
	assign link.miso_oe = miso_oe_q;

endmodule

`default_nettype wire

// [ssi_master.sv]
// Serial master end: makes clock and select, shifts one byte per start
`timescale 1ns/1ns
`default_nettype none
`include "ssi_defs.svh"

module ssi_master #(
	parameter bit SAMPLE_RISE = 1'b1
) (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	output logic            irq,
	ssi_if.mst              link
);

	// =================================================================
	// Declarations
	ssi_pkg::ssi_mst_state_t st_q;
	logic [2:0] div_q;
	logic [3:0] hc_q;
	logic [7:0] sh_q;
	logic [7:0] rx_q;
	logic       msb_q;
	logic       done_q;
	logic       ien_q;
	logic       irq_q;
	logic [7:0] rdata_q;
	logic       m1_q;
	logic       m2_q;
	logic       sck_q;
	logic       ss_n_q;
	logic       mosi_q;

	// =================================================================
	// Decode and timing; clock idles at the level opposite its sample edge
	wire       idle_lvl = ~SAMPLE_RISE;
	wire       tick     = (div_q == 3'(`SSI_HALF_CYC - 1));
	wire       start    = wr_stb & (addr == `SSI_MA_TX) &
	                      (st_q == ssi_pkg::SSI_IDLE);
	wire       samp     = tick & (st_q == ssi_pkg::SSI_SHIFT) & ~hc_q[0];
	wire       drv      = tick & (st_q == ssi_pkg::SSI_SHIFT) & hc_q[0];
	wire       fin      = tick & (st_q == ssi_pkg::SSI_HOLD);
	wire [7:0] shifted  = msb_q ? {sh_q[6:0], m2_q} : {m2_q, sh_q[7:1]};
	wire       first_b  = msb_q ? wdata[7] : wdata[0];
	wire       next_b   = msb_q ? sh_q[7] : sh_q[0];
	wire       iclr     = wr_stb & (addr == `SSI_MA_ICLR) & wdata[0];
	// Bit order may only change between frames
	wire       m_busy   = (st_q != ssi_pkg::SSI_IDLE);
	wire       wr_cfg   = wr_stb & (addr == `SSI_MA_CTRL) & ~m_busy;
	wire [7:0] rd_mux   =
		(addr == `SSI_MA_CTRL) ? {7'h00, msb_q} :
		(addr == `SSI_MA_RX)   ? rx_q :
		(addr == `SSI_MA_STS)  ? {6'h00, m_busy, done_q} :
		(addr == `SSI_MA_IEN)  ? {7'h00, ien_q} : 8'h00;

	// =================================================================
	// Data-in synchroniser
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			m1_q <= 1'b1;
			m2_q <= 1'b1;
		end else begin
			m1_q <= link.miso;
			m2_q <= m1_q;
		end
	end

	// Half-period divider, free running only during a frame
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= 3'h0;
		end else if (st_q == ssi_pkg::SSI_IDLE || tick) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// Sequencer; setup lasts a full period so the slave's first bit lands
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q    <= ssi_pkg::SSI_IDLE;
			hc_q    <= 4'h0;
			sck_q   <= 1'b0;
			ss_n_q  <= 1'b1;
			mosi_q  <= 1'b1;
			sh_q    <= 8'h00;
		end else begin
			unique case (st_q)
				ssi_pkg::SSI_IDLE: begin
					sck_q <= idle_lvl;
					if (start) begin
						st_q    <= ssi_pkg::SSI_SETUP;
						ss_n_q  <= 1'b0;
						sh_q    <= wdata;
						mosi_q  <= first_b;
						hc_q    <= 4'h0;
					end
				end
				ssi_pkg::SSI_SETUP: begin
					if (tick) begin
						hc_q <= hc_q + 4'h1;
						if (hc_q[0]) begin
							st_q <= ssi_pkg::SSI_SHIFT;
							hc_q <= 4'h0;
						end
					end
				end
				ssi_pkg::SSI_SHIFT: begin
					if (tick) begin
						sck_q <= ~sck_q;
						hc_q  <= hc_q + 4'h1;
						if (samp) begin
							sh_q <= shifted;
						end
						if (drv) begin
							mosi_q <= next_b;
						end
						if (hc_q == 4'(2 * `SSI_BITS - 1)) begin
							st_q <= ssi_pkg::SSI_HOLD;
						end
					end
				end
				ssi_pkg::SSI_HOLD: begin
					if (tick) begin
						st_q    <= ssi_pkg::SSI_IDLE;
						ss_n_q  <= 1'b1;
						mosi_q  <= 1'b1;
					end
				end
			endcase
		end
	end

	// =================================================================
	// Registers seen by software; done set wins over its clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			msb_q   <= 1'b1;
			rx_q    <= 8'h00;
			done_q  <= 1'b0;
			ien_q   <= 1'b0;
			irq_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			if (wr_cfg) begin
				msb_q <= wdata[`SSI_MB_MSB];
			end
			if (wr_stb && addr == `SSI_MA_IEN) begin
				ien_q <= wdata[0];
			end
			if (fin) begin
				rx_q <= sh_q;
			end
			done_q  <= fin | (done_q & ~iclr);
			irq_q   <= done_q & ien_q;
			rdata_q <= rd_stb ? rd_mux : 8'h00;
		end
	end

	// =================================================================
	// Outputs
	assign rdata      = rdata_q;
	assign irq        = irq_q;
	assign link.sck   = sck_q;
	assign link.ss_n  = ss_n_q;
	assign link.mosi  = mosi_q;

endmodule

`default_nettype wire

// [ssi_asserts.sv]
// Link protocol checker beside the master and slave ends
`timescale 1ns/1ns
`default_nettype none

module ssi_asserts (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic miso
);
	// =================================================================
	// Sample edges counted within one frame
	logic       sck_q;
	logic [3:0] rise_q;
	logic [3:0] rise_d;

	// Count restarts on deselect so a short frame cannot hide
	assign rise_d = ss_n ? 4'h0 : rise_q + {3'h0, sck & ~sck_q};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_q  <= 1'b0;
			rise_q <= 4'h0;
		end else begin
			sck_q  <= sck;
			rise_q <= rise_d;
		end
	end

	// =================================================================
	// Wire rules
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	AST_FRAME_EIGHT: assert property ($rose(ss_n) |-> rise_q == 4'h8)
		else $error("frame did not carry eight clocks");
	AST_FRAME_LEN: assert property ($fell(ss_n) |->
		##[64:100] $rose(ss_n))
		else $error("frame length out of range");
	AST_HALF: assert property ($changed(sck) |=> $stable(sck)[*3])
		else $error("clock half period too short");
	AST_IDLE_CLOCK: assert property (ss_n |-> !sck)
		else $error("clock not at idle level outside frame");
	AST_SETUP: assert property ($fell(ss_n) |-> !sck[*8])
		else $error("clock started too soon after select");
	AST_IDLE_DATA: assert property (ss_n |-> mosi)
		else $error("master data not idle high");
	AST_MISO_IDLE: assert property (ss_n[*6] |->
		miso && (!miso_oe || miso_o))
		else $error("slave data not idle high");
	AST_MISO_HOLD: assert property ($rose(sck) && !ss_n |->
		$stable(miso)[*2])
		else $error("slave data moved at sample edge");
endmodule

`default_nettype wire

// [ssi_slave_bench.sv]
// Self-checking bench: master end drives the slave end over the link
`timescale 1ns/1ns
`default_nettype none
`include "ssi_defs.svh"

module ssi_slave_bench;
	// Index 0 is the slave port, index 1 the master port
	logic       sys_clk   = 1'b0;
	logic       arst_n    = 1'b0;
	logic [2:0] addr[2]   = '{3'h0, 3'h0};
	logic [7:0] wdata[2]  = '{8'h00, 8'h00};
	logic       wr_stb[2] = '{1'b0, 1'b0};
	logic       rd_stb[2] = '{1'b0, 1'b0};
	logic [7:0] rdata[2];
	logic       irq[2];
	logic [7:0] cap_q     = 8'h00;
	logic       sck_d     = 1'b0;
	logic [7:0] got;
	logic [7:0] exp_q[$];
	logic [7:0] off_ctl[5] = '{8'h0C, 8'h3C, 8'h5C, 8'h7C, 8'h18};
	int         err_total   = 0;
	int         comparisons = 0;
	int         seed        = 99946;

	always #50 sys_clk = ~sys_clk;

	// =================================================================
	// Ends, link and checker
	ssi_if link_a ();
	ssi_slave u_ssi_slave (.sys_clk(sys_clk), .arst_n(arst_n),
		.addr(addr[0]), .wdata(wdata[0]), .wr_stb(wr_stb[0]),
		.rd_stb(rd_stb[0]), .rdata(rdata[0]), .irq(irq[0]), .link(link_a));
	ssi_master u_ssi_master (.sys_clk(sys_clk), .arst_n(arst_n),
		.addr(addr[1]), .wdata(wdata[1]), .wr_stb(wr_stb[1]),
		.rd_stb(rd_stb[1]), .rdata(rdata[1]), .irq(irq[1]), .link(link_a));
	ssi_asserts u_ssi_asserts (.sys_clk(sys_clk), .arst_n(arst_n),
		.sck(link_a.sck), .ss_n(link_a.ss_n), .mosi(link_a.mosi),
		.miso_o(link_a.miso_o), .miso_oe(link_a.miso_oe),
		.miso(link_a.miso));

	// Wire order seen at each sample edge, newest bit lowest
	always @(posedge sys_clk) begin
		sck_d <= link_a.sck;
		if (link_a.sck && !sck_d && !link_a.ss_n) begin
			cap_q <= {cap_q[6:0], link_a.mosi};
		end
	end

	// =================================================================
	// Tasks
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int k = 0; k < 8; k++) begin
			rev[k] = v[7 - k];
		end
	endfunction

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input int m, input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr[m]   <= a;
		wdata[m]  <= d;
		wr_stb[m] <= 1'b1;
		@(posedge sys_clk);
		wr_stb[m] <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input int m, input logic [2:0] a);
		@(posedge sys_clk);
		addr[m]   <= a;
		rd_stb[m] <= 1'b1;
		@(posedge sys_clk);
		rd_stb[m] <= 1'b0;
		#1;
		got = rdata[m];
	endtask

	// Bounded wait: w=0 master interrupt, w=1 select low
	task automatic wait_for(input int w);
		int n;
		for (n = 0; n < 300; n++) begin
			if (w ? link_a.ss_n === 1'b0 : irq[1] === 1'b1) break;
			@(posedge sys_clk);
		end
		if (n == 300) begin
			err_total++;
			wrap_up();
		end
	endtask

	task automatic xfer(input logic [7:0] ts, input logic [7:0] tm);
		wr(0, `SSI_A_DATA, ts);
		wr(1, `SSI_MA_TX, tm);
		wait_for(0);
		wr(1, `SSI_MA_ICLR, 8'h01);
	endtask

	// =================================================================
	// Main sequence
	initial begin
		logic [7:0] ts;
		logic [7:0] tm;
		logic [7:0] ctl;
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(0, `SSI_A_CTRL);
		chk(got, `SSI_CTRL_RST);
		rd(0, 3'h5);
		chk(got, 8'h00);
		rd(1, 3'h7);
		chk(got, 8'h00);
		wr(1, `SSI_MA_IEN, 8'h01);
		$display("test reset done");
		// Both orders, clock source bit flipped, interrupt masked and not
		for (int i = 0; i < 8; i++) begin
			ts = 8'($random(seed));
			tm = 8'($random(seed));
			ctl = {i[1], 3'h1, i[0], 3'h4};
			wr(0, `SSI_A_CTRL, ctl);
			wr(0, `SSI_A_IEN, {7'h00, i[2]});
			wr(1, `SSI_MA_CTRL, {7'h00, i[0]});
			exp_q.push_back(ts);
			exp_q.push_back(tm);
			xfer(ts, tm);
			chk(cap_q, i[0] ? tm : rev(tm));
			rd(1, `SSI_MA_RX);
			chk(got, exp_q.pop_front());
			rd(0, `SSI_A_DATA);
			chk(got, exp_q.pop_front());
			rd(0, `SSI_A_CTRL);
			chk(got, ctl | 8'h01);
			rd(0, `SSI_A_ISTS);
			chk(got, 8'h01);
			chk({7'h00, irq[0]}, {7'h00, i[2]});
			wr(0, `SSI_A_ICLR, 8'h03);
		end
		$display("test transfers done");
		// Data write in mid-frame is dropped and flagged
		wr(0, `SSI_A_CTRL, 8'h1C);
		wr(0, `SSI_A_DATA, 8'hA5);
		wr(1, `SSI_MA_TX, 8'h3C);
		wait_for(1);
		repeat (4) @(posedge sys_clk);
		wr(0, `SSI_A_DATA, 8'h5A);
		// Mid-frame the readable data still holds the previous byte
		rd(0, `SSI_A_DATA);
		chk(got, tm);
		wait_for(0);
		wr(1, `SSI_MA_ICLR, 8'h01);
		rd(1, `SSI_MA_RX);
		chk(got, 8'hA5);
		rd(0, `SSI_A_DATA);
		chk(got, 8'h3C);
		rd(0, `SSI_A_ISTS);
		chk(got, 8'h03);
		rd(0, `SSI_A_CTRL);
		chk(got, 8'h1F);
		wr(0, `SSI_A_CTRL, 8'h1C);
		rd(0, `SSI_A_CTRL);
		chk(got, 8'h1C);
		wr(0, `SSI_A_ICLR, 8'h03);
		xfer(8'h5A, 8'h00);
		rd(1, `SSI_MA_RX);
		chk(got, 8'h5A);
		$display("test collision done");
		// Disabled or master-mode slave leaves the data line pulled high
		foreach (off_ctl[j]) begin
			wr(0, `SSI_A_ICLR, 8'h03);
			wr(0, `SSI_A_CTRL, off_ctl[j]);
			xfer(8'h00, 8'h96);
			rd(1, `SSI_MA_RX);
			chk(got, 8'hFF);
			rd(0, `SSI_A_ISTS);
			chk(got, 8'h00);
		end
		$display("test disabled done");
		wrap_up();
	end
endmodule

`default_nettype wire
